//--- boot_cfg_pkg.sv
package boot_cfg_pkg;
  // Configuration row geometry
  localparam int ROW_AW = 7;
  localparam int ROW_DEPTH = 128;
  // Row offsets of the documented bytes
  localparam logic [6:0] OFS_SOFT_BOOT_VECTOR = 7'h01;
  localparam logic [6:0] OFS_SECURITY_BYTE = 7'h05;
  localparam logic [6:0] OFS_CUSTOMER_SPARE = 7'h06;
  localparam logic [6:0] OFS_MAKER_CODE = 7'h30;
  localparam logic [6:0] OFS_FAMILY_CODE = 7'h31;
  localparam logic [6:0] OFS_MEMORY_TYPE_CODE = 7'h60;
  localparam logic [6:0] OFS_NAME_REVISION_CODE = 7'h61;
  // Row offsets for bytes with no printed place
  localparam logic [6:0] OFS_CUSTOMER_STATUS = 7'h07;
  localparam logic [6:0] OFS_HARDWARE_BYTE = 7'h7F;
  // Hardware byte field positions
  localparam int HWB_DOUBLE_SPEED_BIT = 7;
  localparam int HWB_BOOT_JUMP_BIT = 6;
  localparam int HWB_LOCK_MSB = 2;
  // Software reaches only the upper nibble
  localparam logic [7:0] HWB_SOFTWARE_MASK = 8'hF0;
  // Reset and erase values
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] FLASH_CTRL_RESET = 8'h00;
  localparam logic [7:0] NO_SOFT_LOADER = 8'hFF;
  // Start addresses and boot flash window
  localparam logic [15:0] USER_APP_START = 16'h0000;
  localparam logic [15:0] BOOT_LOADER_START = 16'hF800;
  localparam logic [15:0] BOOT_WINDOW_BASE = 16'hF800;
  localparam logic [7:0] LOADER_LOW_BYTE = 8'h00;
  // Main flash geometry
  localparam int MAIN_AW = 14;
  localparam int PAGE_BYTES = 128;
  localparam logic [6:0] PAGE_LAST = 7'h7F;
  // Main flash command codes
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_BYTE = 2'h1;
  localparam logic [1:0] CMD_PAGE = 2'h2;
  localparam logic [1:0] CMD_ERASE = 2'h3;
endpackage

//--- boot_select_config_row.sv
`timescale 1ns/100ps
// Operation
// - reset loads map enable from jump fuse
// - reset clears flash control register
// - fuse one starts application at zero
// - fuse zero starts loader at F800
// - soft vector gives loader high byte
// - soft vector all ones means none
// - hardware bit 7 selects clock mode
// - hardware bit 6 is jump fuse
// - bits 5-3 reserved, 2-0 lock
// - software reaches only upper hardware nibble
// - vector, spare erase to ones
// - read-only maker and device code copies
// - main flash page, byte, array erase
// - spare and status bytes customer only
// - map enable overlays boot flash top
module boot_select_config_row #(
  parameter logic [7:0] MAKER_CODE = 8'h11, // Arbitrary value
  parameter logic [7:0] FAMILY_CODE = 8'h22, // Arbitrary value
  parameter logic [7:0] MEMORY_TYPE_CODE = 8'h33, // Arbitrary value
  parameter logic [7:0] NAME_REVISION_CODE = 8'h44 // Arbitrary value
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_acc_req,
  input wire logic i_acc_we,
  input wire logic i_acc_par,
  input wire logic [6:0] i_acc_addr,
  input wire logic [7:0] i_acc_wdata,
  input wire logic i_chip_erase,
  input wire logic i_fctl_we,
  input wire logic [7:0] i_fctl_wdata,
  input wire logic [15:0] i_fetch_addr,
  input wire logic [1:0] i_mf_cmd,
  input wire logic i_mf_valid,
  input wire logic [13:0] i_mf_addr,
  input wire logic [7:0] i_mf_wdata,
  output logic [7:0] o_acc_rdata,
  output logic o_acc_ack,
  output logic o_busy,
  output logic o_boot_valid,
  output logic [15:0] o_start_addr,
  output logic o_boot_map_enable,
  output logic o_double_speed,
  output logic [2:0] o_code_lock,
  output logic [15:0] o_soft_loader_addr,
  output logic o_soft_loader_present,
  output logic [7:0] o_flash_ctrl,
  output logic o_fetch_boot_sel,
  output logic o_mf_we,
  output logic o_mf_erase,
  output logic [13:0] o_mf_addr,
  output logic [7:0] o_mf_wdata,
  output logic o_page_done
);
  // Sequencer states
  typedef enum logic [2:0] {S_RD_HWB, S_RD_SBV, S_LATCH, S_RUN, S_ERASE} state_type;

  // Whole module state
  typedef struct packed {
    state_type st;
    logic [6:0] cnt; // Erase walk index
    logic busy;
    logic boot_valid;
    logic boot_flash_map_enable;
    logic x2b; // Double speed, hardware bit 7 inverted
    logic fuse; // Raw hardware bit 6
    logic [2:0] lock;
    logic [15:0] start;
    logic [7:0] soft_boot_vector;
    logic sbl_present; // Vector names a loader
    logic [7:0] fctl;
    logic pend; // Access waiting on memory data
    logic [6:0] pend_addr;
    logic pend_par;
    logic [7:0] rdata;
    logic ack;
    logic fetch_boot;
    logic mf_we;
    logic mf_erase;
    logic [13:0] mf_addr;
    logic [7:0] mf_wdata;
    logic page_act;
    logic [6:0] page_cnt;
    logic page_done;
  } regs_type;

  regs_type cur_q;
  regs_type nxt_d;
  logic mem_we;
  logic [7:0] mem_mask;
  logic [6:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;

  // Bits a write may change at a row offset
  function automatic logic [7:0] write_mask(input logic [6:0] a, input logic par);
    logic [7:0] m;
    m = 8'h00;
    case (a)
      boot_cfg_pkg::OFS_CUSTOMER_SPARE,
      boot_cfg_pkg::OFS_CUSTOMER_STATUS,
      boot_cfg_pkg::OFS_SOFT_BOOT_VECTOR,
      boot_cfg_pkg::OFS_SECURITY_BYTE: m = boot_cfg_pkg::ERASED_BYTE;
      // low nibble only in parallel mode
      boot_cfg_pkg::OFS_HARDWARE_BYTE: m = par ? boot_cfg_pkg::ERASED_BYTE
                                               : boot_cfg_pkg::HWB_SOFTWARE_MASK;
      // Identity copies and unmapped offsets ignore writes
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // Value seen by a read at a row offset
  function automatic logic [7:0] read_view(input logic [6:0] a, input logic par,
                                           input logic [7:0] d);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      boot_cfg_pkg::OFS_MAKER_CODE: v = MAKER_CODE;
      boot_cfg_pkg::OFS_FAMILY_CODE: v = FAMILY_CODE;
      boot_cfg_pkg::OFS_MEMORY_TYPE_CODE: v = MEMORY_TYPE_CODE;
      boot_cfg_pkg::OFS_NAME_REVISION_CODE: v = NAME_REVISION_CODE;
      // software sees low nibble as zero
      boot_cfg_pkg::OFS_HARDWARE_BYTE: v = par ? d : (d & boot_cfg_pkg::HWB_SOFTWARE_MASK);
      boot_cfg_pkg::OFS_CUSTOMER_SPARE,
      boot_cfg_pkg::OFS_CUSTOMER_STATUS,
      boot_cfg_pkg::OFS_SOFT_BOOT_VECTOR,
      boot_cfg_pkg::OFS_SECURITY_BYTE: v = d;
      // Unmapped offsets read zero
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Row storage
  cfg_row_mem u_row (
    .i_mclk(i_mclk),
    .i_we(mem_we),
    .i_mask(mem_mask),
    .i_addr(mem_addr),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata)
  );

  // Next-state logic
  always_comb begin
    nxt_d = cur_q;
    mem_we = 1'b0;
    mem_mask = 8'h00;
    mem_addr = boot_cfg_pkg::OFS_HARDWARE_BYTE;
    mem_wdata = boot_cfg_pkg::ERASED_BYTE;
    nxt_d.ack = 1'b0;
    nxt_d.pend = 1'b0;
    nxt_d.mf_we = 1'b0;
    nxt_d.mf_erase = 1'b0;
    nxt_d.page_done = 1'b0;
    // Finish a pending access with fresh memory data
    if (cur_q.pend) begin
      nxt_d.rdata = read_view(cur_q.pend_addr, cur_q.pend_par, mem_rdata);
      nxt_d.ack = 1'b1;
    end
    case (cur_q.st)
      // Hardware byte read issued after reset release
      S_RD_HWB: begin
        mem_addr = boot_cfg_pkg::OFS_HARDWARE_BYTE;
        nxt_d.st = S_RD_SBV;
      end
      // Hardware byte arrives, vector read issued
      S_RD_SBV: begin
        mem_addr = boot_cfg_pkg::OFS_SOFT_BOOT_VECTOR;
        nxt_d.x2b = ~mem_rdata[boot_cfg_pkg::HWB_DOUBLE_SPEED_BIT];
        // bit 6 holds the jump fuse
        nxt_d.fuse = mem_rdata[boot_cfg_pkg::HWB_BOOT_JUMP_BIT];
        nxt_d.lock = mem_rdata[boot_cfg_pkg::HWB_LOCK_MSB:0];
        nxt_d.boot_flash_map_enable = ~mem_rdata[boot_cfg_pkg::HWB_BOOT_JUMP_BIT];
        nxt_d.st = S_LATCH;
      end
      // Vector arrives, start address chosen
      S_LATCH: begin
        nxt_d.soft_boot_vector = mem_rdata;
        // all ones vector means no loader
        nxt_d.sbl_present = (mem_rdata != boot_cfg_pkg::NO_SOFT_LOADER);
        nxt_d.start = cur_q.fuse ? boot_cfg_pkg::USER_APP_START
                                 : boot_cfg_pkg::BOOT_LOADER_START;
        nxt_d.boot_valid = 1'b1;
        nxt_d.busy = 1'b0;
        nxt_d.st = S_RUN;
      end
      // Normal operation: accesses, erase start, control register writes
      S_RUN: begin
        if (i_chip_erase) begin
          // Erase wins over an access in the same cycle
          nxt_d.busy = 1'b1;
          nxt_d.cnt = 7'h00;
          nxt_d.st = S_ERASE;
        end else if (i_acc_req) begin
          mem_addr = i_acc_addr;
          mem_wdata = i_acc_wdata;
          mem_we = i_acc_we;
          mem_mask = write_mask(i_acc_addr, i_acc_par);
          nxt_d.pend = 1'b1;
          nxt_d.pend_addr = i_acc_addr;
          nxt_d.pend_par = i_acc_par;
        end
        // control register writable only once running
        if (i_fctl_we) begin
          nxt_d.fctl = i_fctl_wdata;
        end
      end
      // every row byte walked to all ones
      S_ERASE: begin
        mem_we = 1'b1;
        mem_mask = boot_cfg_pkg::ERASED_BYTE;
        mem_addr = cur_q.cnt;
        mem_wdata = boot_cfg_pkg::ERASED_BYTE;
        nxt_d.cnt = cur_q.cnt + 7'h01;
        if (cur_q.cnt == boot_cfg_pkg::PAGE_LAST) begin
          nxt_d.busy = 1'b0;
          nxt_d.st = S_RUN;
        end
      end
      default: begin
        nxt_d.st = S_RD_HWB;
      end
    endcase
    // boot flash overlays the top window
    nxt_d.fetch_boot = cur_q.boot_flash_map_enable && cur_q.boot_valid
                       && (i_fetch_addr >= boot_cfg_pkg::BOOT_WINDOW_BASE);
    // main flash byte, page and erase commands
    if (i_mf_valid && cur_q.boot_valid) begin
      case (i_mf_cmd)
        boot_cfg_pkg::CMD_BYTE: begin
          nxt_d.mf_we = 1'b1;
          nxt_d.mf_addr = i_mf_addr;
          nxt_d.mf_wdata = i_mf_wdata;
          nxt_d.page_act = 1'b0;
        end
        boot_cfg_pkg::CMD_PAGE: begin
          // First byte opens the page, later bytes walk within it
          nxt_d.mf_we = 1'b1;
          nxt_d.mf_wdata = i_mf_wdata;
          if (!cur_q.page_act) begin
            nxt_d.mf_addr = {i_mf_addr[13:7], 7'h00};
            nxt_d.page_cnt = 7'h01;
            nxt_d.page_act = 1'b1;
          end else begin
            nxt_d.mf_addr = {cur_q.mf_addr[13:7], cur_q.page_cnt};
            nxt_d.page_cnt = cur_q.page_cnt + 7'h01;
            if (cur_q.page_cnt == boot_cfg_pkg::PAGE_LAST) begin
              nxt_d.page_act = 1'b0;
              nxt_d.page_done = 1'b1;
            end
          end
        end
        boot_cfg_pkg::CMD_ERASE: begin
          nxt_d.mf_erase = 1'b1;
          nxt_d.page_act = 1'b0;
        end
        default: begin
          nxt_d.page_act = cur_q.page_act;
        end
      endcase
    end
  end

  // State register; reset restarts the capture walk
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cur_q <= '0;
      cur_q.st <= S_RD_HWB;
      cur_q.busy <= 1'b1;
      cur_q.fctl <= boot_cfg_pkg::FLASH_CTRL_RESET;
      cur_q.soft_boot_vector <= boot_cfg_pkg::NO_SOFT_LOADER;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // Outputs straight from the state register
  assign o_acc_rdata = cur_q.rdata;
  assign o_acc_ack = cur_q.ack;
  assign o_busy = cur_q.busy;
  assign o_boot_valid = cur_q.boot_valid;
  assign o_start_addr = cur_q.start;
  assign o_boot_map_enable = cur_q.boot_flash_map_enable;
  // flop already holds the inverted bit
  assign o_double_speed = cur_q.x2b;
  assign o_code_lock = cur_q.lock;
  // loader entry is vector then zero
  assign o_soft_loader_addr = {cur_q.soft_boot_vector, boot_cfg_pkg::LOADER_LOW_BYTE};
  // all ones vector means no loader
  assign o_soft_loader_present = cur_q.sbl_present;
  assign o_flash_ctrl = cur_q.fctl;
  assign o_fetch_boot_sel = cur_q.fetch_boot;
  assign o_mf_we = cur_q.mf_we;
  assign o_mf_erase = cur_q.mf_erase;
  assign o_mf_addr = cur_q.mf_addr;
  assign o_mf_wdata = cur_q.mf_wdata;
  assign o_page_done = cur_q.page_done;

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  sequence s_acc_taken;
    i_acc_req && cur_q.st == S_RUN && !i_chip_erase;
  endsequence
  sequence s_erase_walk;
    o_busy [*8] ##[120:124] !o_busy;
  endsequence

  property p_boot_flash_map_enable_fuse;
    $rose(o_boot_valid) |-> o_boot_map_enable == !cur_q.fuse;
  endproperty
  a_boot_flash_map_enable_fuse: assert property (p_boot_flash_map_enable_fuse) else $error("map enable not from fuse");
  property p_fctl_clear;
    $rose(o_boot_valid) |-> o_flash_ctrl == boot_cfg_pkg::FLASH_CTRL_RESET;
  endproperty
  a_fctl_clear: assert property (p_fctl_clear) else $error("control not cleared");
  property p_start_app;
    $rose(o_boot_valid) && cur_q.fuse |-> o_start_addr == boot_cfg_pkg::USER_APP_START;
  endproperty
  a_start_app: assert property (p_start_app) else $error("wrong application start");
  property p_start_loader;
    $rose(o_boot_valid) && !cur_q.fuse |-> o_start_addr == boot_cfg_pkg::BOOT_LOADER_START;
  endproperty
  a_start_loader: assert property (p_start_loader) else $error("wrong loader start");
  property p_no_loader;
    o_boot_valid && o_soft_loader_addr[15:8] == boot_cfg_pkg::NO_SOFT_LOADER
      |-> !o_soft_loader_present;
  endproperty
  a_no_loader: assert property (p_no_loader) else $error("all ones vector seen as loader");
  property p_sw_hwb;
    mem_we && !i_acc_par && mem_addr == boot_cfg_pkg::OFS_HARDWARE_BYTE && cur_q.st == S_RUN
      |-> mem_mask == boot_cfg_pkg::HWB_SOFTWARE_MASK;
  endproperty
  a_sw_hwb: assert property (p_sw_hwb) else $error("software reached low nibble");
  property p_erase;
    i_chip_erase && cur_q.st == S_RUN |=> s_erase_walk;
  endproperty
  a_erase: assert property (p_erase) else $error("erase walk length wrong");
  property p_id_read;
    s_acc_taken and (i_acc_addr == boot_cfg_pkg::OFS_MAKER_CODE)
      |-> ##2 o_acc_ack && o_acc_rdata == MAKER_CODE;
  endproperty
  a_id_read: assert property (p_id_read) else $error("maker copy read wrong");
  property p_map;
    o_boot_valid && o_boot_map_enable && i_fetch_addr >= boot_cfg_pkg::BOOT_WINDOW_BASE
      |=> o_fetch_boot_sel;
  endproperty
  a_map: assert property (p_map) else $error("boot window not mapped");
  property p_stable;
    o_boot_valid |=> $stable(o_start_addr) && $stable(o_boot_map_enable) && $stable(o_code_lock);
  endproperty
  a_stable: assert property (p_stable) else $error("boot choice changed");
endmodule

//--- boot_select_config_row_tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module boot_select_config_row_tb_top;
  logic i_mclk = 1'b0; // 250 MHz clock
  logic i_resetn = 1'b0; // Active low reset
  logic i_acc_req, i_acc_we, i_acc_par, i_chip_erase, i_fctl_we, i_mf_valid;
  logic [6:0] i_acc_addr; // Row offset
  logic [7:0] i_acc_wdata, i_fctl_wdata, i_mf_wdata;
  logic [15:0] i_fetch_addr; // Driven by the core model
  logic [1:0] i_mf_cmd; // Main flash command
  logic [13:0] i_mf_addr; // Main flash address
  logic [7:0] o_acc_rdata, o_flash_ctrl, o_mf_wdata;
  logic o_acc_ack, o_busy, o_boot_valid, o_boot_map_enable, o_double_speed;
  logic o_soft_loader_present, o_fetch_boot_sel, o_mf_we, o_mf_erase, o_page_done;
  logic [15:0] o_start_addr, o_soft_loader_addr;
  logic [2:0] o_code_lock; // Captured lock bits
  logic [13:0] o_mf_addr; // Main flash write address
  int err_total = 0; // Mismatches
  int check_count = 0; // Comparisons

  // Clock
  always #2 i_mclk = ~i_mclk;

  boot_select_config_row dut_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_acc_req(i_acc_req),
    .i_acc_we(i_acc_we), .i_acc_par(i_acc_par), .i_acc_addr(i_acc_addr),
    .i_acc_wdata(i_acc_wdata), .i_chip_erase(i_chip_erase), .i_fctl_we(i_fctl_we),
    .i_fctl_wdata(i_fctl_wdata), .i_fetch_addr(i_fetch_addr), .i_mf_cmd(i_mf_cmd),
    .i_mf_valid(i_mf_valid), .i_mf_addr(i_mf_addr), .i_mf_wdata(i_mf_wdata),
    .o_acc_rdata(o_acc_rdata), .o_acc_ack(o_acc_ack), .o_busy(o_busy),
    .o_boot_valid(o_boot_valid), .o_start_addr(o_start_addr),
    .o_boot_map_enable(o_boot_map_enable), .o_double_speed(o_double_speed),
    .o_code_lock(o_code_lock), .o_soft_loader_addr(o_soft_loader_addr),
    .o_soft_loader_present(o_soft_loader_present), .o_flash_ctrl(o_flash_ctrl),
    .o_fetch_boot_sel(o_fetch_boot_sel), .o_mf_we(o_mf_we), .o_mf_erase(o_mf_erase),
    .o_mf_addr(o_mf_addr), .o_mf_wdata(o_mf_wdata), .o_page_done(o_page_done));

  // Slow core on the far side
  core_fetch_model #(.STEP(3)) core_u (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_boot_valid(o_boot_valid), .i_start_addr(o_start_addr), .o_fetch_addr(i_fetch_addr));

  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Step to just after the next rising edge
  task automatic tick;
    @(posedge i_mclk);
    #1;
  endtask

  // A wait that ran out
  task automatic hang;
    err_total++;
    $display("ERROR t=%0t wait ran out", $time);
    wrap_up();
  endtask

  // Wait for capture or erase to finish, bounded
  task automatic wait_idle(input int lim);
    for (int n = 0; n < lim; n++) begin
      if (o_busy === 1'b0 && o_boot_valid === 1'b1) return;
      tick();
    end
    hang();
  endtask

  // Reset held 6 cycles, then boot capture
  task automatic do_reset;
    i_resetn = 1'b0;
    repeat (6) tick();
    i_resetn = 1'b1;
    wait_idle(20);
  endtask

  // One row access; request lasts one cycle, answer waited for
  task automatic acc(input logic par, we, input logic [6:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    i_acc_par = par;
    i_acc_we = we;
    i_acc_addr = a;
    i_acc_wdata = d;
    i_acc_req = 1'b1;
    tick();
    i_acc_req = 1'b0;
    for (int n = 0; n < 4; n++) begin
      tick();
      if (o_acc_ack === 1'b1) begin
        q = o_acc_rdata;
        return;
      end
    end
    hang();
  endtask

  // Erase the row, boot from it, expect the user application
  task automatic s_erased_boot;
    logic [7:0] q;
    i_chip_erase = 1'b1;
    tick();
    i_chip_erase = 1'b0;
    for (int n = 0; n < 128; n++) begin
      `CHK(o_busy, 1'b1)
      tick();
    end
    `CHK(o_busy, 1'b0)
    do_reset();
    `CHK(o_boot_valid, 1'b1)
    `CHK(o_start_addr, 16'h0000)
    `CHK(o_boot_map_enable, 1'b0)
    `CHK(o_double_speed, 1'b0)
    `CHK(o_code_lock, 3'h7)
    `CHK(o_soft_loader_present, 1'b0)
    `CHK(o_flash_ctrl, 8'h00)
    repeat (8) tick();
    `CHK(o_fetch_boot_sel, 1'b0)
    acc(1'b0, 1'b0, boot_cfg_pkg::OFS_SOFT_BOOT_VECTOR, 8'h00, q);
    `CHK(q, 8'hFF)
    acc(1'b0, 1'b0, boot_cfg_pkg::OFS_CUSTOMER_SPARE, 8'h00, q);
    `CHK(q, 8'hFF)
  endtask

  // Identity copies, customer bytes and an unmapped place
  task automatic s_row_bytes;
    logic [7:0] q;
    logic [6:0] ofs [4] = '{7'h30, 7'h31, 7'h60, 7'h61};
    logic [7:0] ids [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    acc(1'b1, 1'b1, 7'h30, 8'h00, q);
    for (int n = 0; n < 4; n++) begin
      acc(1'b0, 1'b0, ofs[n], 8'h00, q);
      `CHK(q, ids[n])
    end
    acc(1'b0, 1'b1, boot_cfg_pkg::OFS_CUSTOMER_SPARE, 8'h5A, q);
    acc(1'b0, 1'b1, boot_cfg_pkg::OFS_CUSTOMER_STATUS, 8'hA5, q);
    acc(1'b0, 1'b0, boot_cfg_pkg::OFS_CUSTOMER_SPARE, 8'h00, q);
    `CHK(q, 8'h5A)
    acc(1'b0, 1'b0, boot_cfg_pkg::OFS_CUSTOMER_STATUS, 8'h00, q);
    `CHK(q, 8'hA5)
    acc(1'b0, 1'b0, 7'h10, 8'h00, q);
    `CHK(q, 8'h00)
  endtask

  // Program fuse and vector, reboot into the loader, then try to disturb it
  task automatic s_loader_boot;
    logic [7:0] q;
    acc(1'b1, 1'b1, boot_cfg_pkg::OFS_HARDWARE_BYTE, 8'h3A, q);
    acc(1'b0, 1'b1, boot_cfg_pkg::OFS_SOFT_BOOT_VECTOR, 8'h40, q);
    i_fctl_wdata = 8'h5A;
    i_fctl_we = 1'b1;
    tick();
    i_fctl_we = 1'b0;
    tick();
    `CHK(o_flash_ctrl, 8'h5A)
    do_reset();
    `CHK(o_flash_ctrl, 8'h00)
    `CHK(o_start_addr, 16'hF800)
    `CHK(o_boot_map_enable, 1'b1)
    `CHK(o_double_speed, 1'b1)
    `CHK(o_code_lock, 3'h2)
    `CHK(o_soft_loader_addr, 16'h4000)
    `CHK(o_soft_loader_present, 1'b1)
    repeat (8) tick();
    `CHK(o_fetch_boot_sel, 1'b1)
    acc(1'b0, 1'b1, boot_cfg_pkg::OFS_HARDWARE_BYTE, 8'hCF, q);
    repeat (2) tick();
    `CHK(o_start_addr, 16'hF800)
    `CHK(o_double_speed, 1'b1)
    `CHK(o_boot_map_enable, 1'b1)
    acc(1'b0, 1'b0, boot_cfg_pkg::OFS_HARDWARE_BYTE, 8'h00, q);
    `CHK(q, 8'hC0)
    acc(1'b1, 1'b0, boot_cfg_pkg::OFS_HARDWARE_BYTE, 8'h00, q);
    `CHK(q, 8'hCA)
  endtask

  // One main flash command, watching the pulses that follow
  task automatic mf_one(input logic [1:0] c, input logic [13:0] a, output logic we, er,
                        output logic [13:0] wa);
    we = 1'b0;
    er = 1'b0;
    i_mf_cmd = c;
    i_mf_addr = a;
    i_mf_wdata = 8'h5C;
    i_mf_valid = 1'b1;
    tick();
    i_mf_valid = 1'b0;
    // Pulse stands in the cycle right after the taking edge
    for (int n = 0; n < 3; n++) begin
      if (o_mf_erase === 1'b1) er = 1'b1;
      if (o_mf_we === 1'b1) begin
        we = 1'b1;
        wa = o_mf_addr;
      end
      tick();
    end
  endtask

  // Full page from a mid-page address, then erase and a single byte
  task automatic s_main_flash;
    logic [13:0] last;
    logic we, er;
    int wr = 0;
    logic done = 1'b0;
    for (int n = 0; n < 131; n++) begin
      i_mf_valid = (n < 128);
      i_mf_cmd = boot_cfg_pkg::CMD_PAGE;
      i_mf_addr = 14'h0085 + 14'(n);
      i_mf_wdata = 8'(n);
      tick();
      if (o_mf_we === 1'b1) begin
        if (wr == 0) `CHK(o_mf_addr, 14'h0080)
        `CHK(o_mf_wdata, 8'(wr))
        wr++;
        last = o_mf_addr;
      end
      if (o_page_done === 1'b1) done = 1'b1;
    end
    `CHK(wr, 128)
    `CHK(last, 14'h00FF)
    `CHK(done, 1'b1)
    mf_one(boot_cfg_pkg::CMD_ERASE, 14'h0000, we, er, last);
    `CHK(er, 1'b1)
    mf_one(boot_cfg_pkg::CMD_BYTE, 14'h1234, we, er, last);
    `CHK(we, 1'b1)
    `CHK(last, 14'h1234)
  endtask

  // Main sequence
  initial begin
    {i_acc_req, i_acc_we, i_acc_par, i_chip_erase, i_fctl_we, i_mf_valid} = '0;
    i_acc_addr = 7'h00;
    i_acc_wdata = 8'h00;
    i_fctl_wdata = 8'h00;
    i_mf_wdata = 8'h00;
    i_mf_cmd = boot_cfg_pkg::CMD_NONE;
    i_mf_addr = 14'h0000;
    do_reset();
    s_erased_boot();
    s_row_bytes();
    s_loader_boot();
    s_main_flash();
    wrap_up();
  end
endmodule

//--- cfg_row_mem.sv
`timescale 1ns/100ps
// Nonvolatile row image, bit-masked write, registered read
module cfg_row_mem (
  input wire logic i_mclk,
  input wire logic i_we,
  input wire logic [7:0] i_mask,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  // No reset: contents survive a device reset like the real cells
  // Cells start erased, so the first boot never reads unknown bits
  logic [7:0] mem_q [0:boot_cfg_pkg::ROW_DEPTH-1] = '{default: boot_cfg_pkg::ERASED_BYTE};

  // Masked write keeps untouched bits, read data always registered
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem_q[i_addr] <= (mem_q[i_addr] & ~i_mask) | (i_wdata & i_mask);
    end
    o_rdata <= mem_q[i_addr];
  end
endmodule

//--- core_fetch_model.sv
`timescale 1ns/100ps
// Core model: fetches in sequence from the start address the block chose
module core_fetch_model #(
  parameter int STEP = 1 // Cycles per fetch; above 1 models a slow core
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_boot_valid,
  input wire logic [15:0] i_start_addr,
  output logic [15:0] o_fetch_addr
);
  int wait_q; // Cycles left before the next fetch
  logic run_q; // Fetching has begun
  // Sequencer; before boot the bus wanders so no stale address looks real
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fetch_addr <= 16'h5A5A;
      run_q <= 1'b0;
      wait_q <= 0;
    end else if (!i_boot_valid) begin
      o_fetch_addr <= ~o_fetch_addr;
      run_q <= 1'b0;
    end else if (!run_q) begin
      o_fetch_addr <= i_start_addr;
      run_q <= 1'b1;
      wait_q <= STEP - 1;
    end else if (wait_q != 0) begin
      wait_q <= wait_q - 1;
    end else begin
      o_fetch_addr <= o_fetch_addr + 16'h0001;
      wait_q <= STEP - 1;
    end
  end
endmodule
